//--- src/field_io_scan_timestamp.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`include "field_io_map.svh"

module field_io_scan_timestamp #(
    parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
    // Clock and power-up reset
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    // Reset line from the CPU module, and module reset out
    input  wire logic                    cpu_reset_n,
    output logic                         module_reset_n,
    // Field wiring
    input  wire logic [`NUM_IO-1:0]      field_in_n,
    output logic [`NUM_IO-1:0]           field_out,
    input  wire logic                    mains_phase_ref,
    input  wire logic                    monitor_jumper,
    // Register port
    input  field_io_pkg::bus_req_t       bus_req,
    output logic [31:0]                  rdata
);
    import field_io_pkg::*;

    // Synchronisers
    logic [`NUM_IO-1:0] in_s1_r, in_s2_r;
    logic               cpu_s1_r, cpu_s2_r;
    logic               ph_s1_r, ph_s2_r, ph_d_r;
    logic               jmp_s1_r, jmp_s2_r;
    // Reset, time base, timestamp
    logic               mod_rst_r, wd_bite_r;
    logic [16:0]        ms_cnt_r;
    logic               tick;
    logic [31:0]        ts_r, scan_ts_r, ts_inc;
    // Scanner
    scan_state_t        st_r;
    logic [`IDX_W-1:0]  scan_idx_r, cfg_sel_r;
    logic [`NUM_IO-1:0] raw_r, filt_r, flip;
    in_cfg_t            cfg_r [`NUM_IO];
    logic [7:0]         cnt_r [`NUM_IO];
    // Outputs, watchdog, monitor, comm
    logic [`NUM_IO-1:0] out_r, shadow_r;
    logic               wd_en_r, sync_ext_r;
    logic [6:0]         wd_ms_r, mon_ph_r;
    logic [11:0]        mon_span_r;
    logic [10:0]        comm_ms_r;
    logic               loss_r, e_clr_r, comm_to;
    // Buffer
    logic               push, buf_full, buf_empty;
    entry_t             push_data, peek_data;
    logic [`BUF_AW:0]   buf_count;
    // Decoded strobes
    logic               wr_ctrl, wr_commit, rd_buf;
    logic               mon_tog, scanning, roll;

    assign wr_ctrl   = bus_req.wr && (bus_req.addr == `A_CTRL);
    assign wr_commit = bus_req.wr && (bus_req.addr == `A_OUT_COMMIT);
    assign rd_buf    = bus_req.rd && (bus_req.addr == `A_BUF_DATA);
    assign scanning  = (st_r == SCAN_RUN);

    // Pin synchronisers, two flops each
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            in_s1_r  <= '0;
            in_s2_r  <= '0;
            cpu_s1_r <= 1'b1;
            cpu_s2_r <= 1'b1;
            ph_s1_r  <= 1'b0;
            ph_s2_r  <= 1'b0;
            ph_d_r   <= 1'b0;
            jmp_s1_r <= 1'b0;
            jmp_s2_r <= 1'b0;
        end else begin
            in_s1_r  <= ~field_in_n;
            in_s2_r  <= in_s1_r;
            cpu_s1_r <= cpu_reset_n;
            cpu_s2_r <= cpu_s1_r;
            ph_s1_r  <= mains_phase_ref;
            ph_s2_r  <= ph_s1_r;
            ph_d_r   <= ph_s2_r;
            jmp_s1_r <= monitor_jumper;
            jmp_s2_r <= jmp_s1_r;
        end
    end

    // Either reset line, or a watchdog bite, resets everything but the synchronisers and the bite flop
    always_ff @(posedge ref_clk) begin
        mod_rst_r      <= !reset_n || !cpu_s2_r || wd_bite_r;
        module_reset_n <= reset_n && cpu_s2_r && !wd_bite_r;
    end

    // Millisecond divider; an exact divide keeps the crystal's accuracy
    assign tick = (ms_cnt_r == 17'(MS_CYCLES - 1));
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r) begin
            ms_cnt_r <= '0;
        end else if ((sync_ext_r && ph_s2_r && !ph_d_r) ||
                     (wr_ctrl && bus_req.wdata[`CTRL_RESYNC])) begin
            ms_cnt_r <= '0;
        end else if (tick) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 17'h00001;
        end
    end

    // Timestamp counter, free-running modulo 2^32
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r) begin
            ts_r <= '0;
        end else if (tick) begin
            ts_r <= ts_r + 32'h00000001;
        end
    end

    // Rollover when the low half passes from all ones to zero
    assign roll = tick && (ts_r[15:0] == 16'hffff);
    assign ts_inc = ts_r + 32'h00000001;      // High half after the wrap, not before

    // Scan sequencer: one input per cycle, 64 cycles well under 100 us
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r) begin
            st_r       <= SCAN_IDLE;
            scan_idx_r <= '0;
            scan_ts_r  <= '0;
        end else begin
            unique case (st_r)
                SCAN_IDLE: begin
                    if (tick) begin
                        st_r       <= SCAN_RUN;
                        scan_idx_r <= '0;
                        scan_ts_r  <= ts_r + 32'h00000001;
                    end
                end
                SCAN_RUN: begin
                    scan_idx_r <= scan_idx_r + 1'b1;
                    if (scan_idx_r == `IDX_W'(`NUM_IO - 1)) begin
                        st_r <= SCAN_IDLE;
                    end
                end
            endcase
        end
    end

    // Per-input filter state and configuration
    genvar g;
    generate
        for (g = 0; g < `NUM_IO; g++) begin : g_in
            logic [7:0] thr;
            logic       differs;
            assign thr     = in_s2_r[g] ? cfg_r[g].on_cnt : cfg_r[g].off_cnt;
            assign differs = (in_s2_r[g] != filt_r[g]);
            assign flip[g] = differs && ((thr == 8'h00) ||
                             ({1'b0, cnt_r[g]} + 9'h001 >= {1'b0, thr}));

            always_ff @(posedge ref_clk) begin
                if (mod_rst_r) begin
                    cfg_r[g] <= '{report: 1'b0, ignore: 1'b0,
                                  off_cnt: `FILT_DEFAULT, on_cnt: `FILT_DEFAULT};
                end else if (bus_req.wr && (bus_req.addr == `A_CFG_DATA) &&
                             (cfg_sel_r == `IDX_W'(g))) begin
                    cfg_r[g] <= in_cfg_t'(bus_req.wdata[17:0]);
                end
            end

            // Sample is held in raw_r until this input's slot comes again
            always_ff @(posedge ref_clk) begin
                if (mod_rst_r) begin
                    raw_r[g]  <= 1'b0;
                    filt_r[g] <= 1'b0;
                    cnt_r[g]  <= 8'h00;
                end else if (scanning && (scan_idx_r == `IDX_W'(g))) begin
                    raw_r[g] <= in_s2_r[g];
                    if (!differs || flip[g]) begin
                        cnt_r[g] <= 8'h00;
                    end else begin
                        cnt_r[g] <= cnt_r[g] + 8'h01;
                    end
                    if (flip[g]) begin
                        filt_r[g] <= in_s2_r[g];
                    end
                end
            end
        end
    endgenerate

    // Entry producer; rollovers land on the tick, scan pushes follow it
    always_comb begin
        push      = 1'b0;
        push_data = '0;
        if (roll) begin
            push      = 1'b1;
            push_data = '{b1: `ROLL_ID, b2: ts_inc[31:24], b3: ts_inc[23:16]};
        end else if (scanning && flip[scan_idx_r] && cfg_r[scan_idx_r].report &&
                     !cfg_r[scan_idx_r].ignore) begin
            push      = 1'b1;
            push_data = '{b1: {in_s2_r[scan_idx_r], 1'b0, scan_idx_r},
                          b2: scan_ts_r[15:8], b3: scan_ts_r[7:0]};
        end
    end

    entry_buffer u_buf (
        .ref_clk   (ref_clk),
        .rst       (mod_rst_r),
        .push      (push),
        .push_data (push_data),
        .pull      (rd_buf),
        .confirm   (bus_req.wr && (bus_req.addr == `A_BUF_CONFIRM)),
        .rewind    (bus_req.wr && (bus_req.addr == `A_BUF_REWIND)),
        .peek_data (peek_data),
        .count     (buf_count),
        .full      (buf_full),
        .empty     (buf_empty)
    );

    // Watchdog: nothing clears the enable; a module reset sets it
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r) begin
            wd_en_r    <= 1'b1;
            sync_ext_r <= 1'b0;
            cfg_sel_r  <= '0;
        end else begin
            if (wr_ctrl && bus_req.wdata[`CTRL_WD_EN]) begin
                wd_en_r <= 1'b1;
            end
            if (wr_ctrl) begin
                sync_ext_r <= bus_req.wdata[`CTRL_SYNC_EXT];
            end
            if (bus_req.wr && (bus_req.addr == `A_CFG_SEL)) begin
                cfg_sel_r <= bus_req.wdata[`IDX_W-1:0];
            end
        end
    end

    // Watchdog timer in milliseconds; the bite flop escapes module reset
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wd_bite_r <= 1'b0;
        end else begin
            wd_bite_r <= !mod_rst_r && wd_en_r && tick &&
                         (wd_ms_r == `WD_TIMEOUT_MS - 7'h01);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r || (wr_ctrl && bus_req.wdata[`CTRL_WD_KICK])) begin
            wd_ms_r <= '0;
        end else if (tick && (wd_ms_r != `WD_TIMEOUT_MS - 7'h01)) begin
            wd_ms_r <= wd_ms_r + 7'h01;
        end
    end

    // Monitor toggle, with the jumper fitted only: a fixed burst after reset release, or on command
    assign mon_tog = jmp_s2_r && ((tick && (mon_span_r != `MON_SPAN_MS) &&
                     (mon_ph_r == `MON_PERIOD_MS - 7'h01)) ||
                     (wr_ctrl && bus_req.wdata[`CTRL_MON_TOG]));
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r) begin
            mon_span_r <= '0;
            mon_ph_r   <= '0;
        end else if (tick && (mon_span_r != `MON_SPAN_MS)) begin
            mon_span_r <= mon_span_r + 12'h001;
            mon_ph_r   <= (mon_ph_r == `MON_PERIOD_MS - 7'h01) ? 7'h00 : mon_ph_r + 7'h01;
        end
    end

    // Communication loss timer; any register access counts as traffic
    assign comm_to = tick && (comm_ms_r == `COMM_LOSS_MS - 11'h001);
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r || bus_req.wr || bus_req.rd) begin
            comm_ms_r <= '0;
        end else if (tick && !comm_to) begin
            comm_ms_r <= comm_ms_r + 11'h001;
        end
    end

    // Loss flag: timeout set wins over a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r) begin
            loss_r  <= 1'b1;
            e_clr_r <= 1'b0;
        end else if (comm_to) begin
            loss_r  <= 1'b1;
            e_clr_r <= 1'b0;
        end else if (wr_ctrl && bus_req.wdata[`CTRL_STAT_REQ]) begin
            e_clr_r <= 1'b1;
        end else if (wr_commit && e_clr_r) begin
            loss_r  <= 1'b0;
            e_clr_r <= 1'b0;
        end
    end

    // Output shadow, loaded in halves and applied in one edge
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r) begin
            shadow_r <= '0;
        end else if (bus_req.wr && (bus_req.addr == `A_OUT_LO)) begin
            shadow_r[31:0] <= bus_req.wdata;
        end else if (bus_req.wr && (bus_req.addr == `A_OUT_HI)) begin
            shadow_r[63:32] <= bus_req.wdata;
        end
    end

    // Field outputs; one register so untouched bits cannot glitch
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r || comm_to) begin
            out_r <= '0;
        end else if (wr_commit) begin
            out_r <= shadow_r;
        end else if (mon_tog) begin
            out_r[`MON_BIT] <= ~out_r[`MON_BIT];
        end
    end
    assign field_out = out_r;

    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge ref_clk) begin
        if (mod_rst_r || !bus_req.rd) begin
            rdata <= '0;
        end else begin
            unique case (bus_req.addr)
                `A_CTRL:      rdata <= {27'h0, sync_ext_r, 3'h0, wd_en_r};
                `A_STATUS:    rdata <= {26'h0, scanning, jmp_s2_r, buf_full,
                                        buf_empty, loss_r, wd_en_r};
                `A_OUT_LO:    rdata <= out_r[31:0];
                `A_OUT_HI:    rdata <= out_r[63:32];
                `A_IN_LO:     rdata <= filt_r[31:0];
                `A_IN_HI:     rdata <= filt_r[63:32];
                `A_TSTAMP:    rdata <= ts_r;
                `A_CFG_SEL:   rdata <= {26'h0, cfg_sel_r};
                `A_CFG_DATA:  rdata <= {14'h0, cfg_r[cfg_sel_r]};
                `A_BUF_DATA:  rdata <= {8'h0, peek_data};
                `A_BUF_COUNT: rdata <= {21'h0, buf_count};
                default:      rdata <= '0;
            endcase
        end
    end

    // Checks
    property p_tick_starts_scan;
        @(posedge ref_clk) disable iff (mod_rst_r)
        (tick && st_r == SCAN_IDLE) |=> (scanning && scan_idx_r == '0);
    endproperty
    a_tick_starts_scan: assert property (p_tick_starts_scan)
        else $error("scan did not start on tick");

    property p_scan_ascends;
        @(posedge ref_clk) disable iff (mod_rst_r)
        (scanning && scan_idx_r != `IDX_W'(`NUM_IO - 1)) |=>
            (scanning && scan_idx_r == $past(scan_idx_r) + 1'b1);
    endproperty
    a_scan_ascends: assert property (p_scan_ascends)
        else $error("scan order broken");

    property p_scan_ends;
        @(posedge ref_clk) disable iff (mod_rst_r)
        (scanning && scan_idx_r == `IDX_W'(`NUM_IO - 1)) |=> (st_r == SCAN_IDLE);
    endproperty
    a_scan_ends: assert property (p_scan_ends)
        else $error("scan overran last input");

    property p_ts_inc;
        @(posedge ref_clk) disable iff (mod_rst_r)
        tick |=> (ts_r == $past(ts_r) + 32'h00000001);
    endproperty
    a_ts_inc: assert property (p_ts_inc)
        else $error("timestamp did not advance");

    property p_roll_entry;
        @(posedge ref_clk) disable iff (mod_rst_r)
        roll |-> (push && push_data.b1 == `ROLL_ID &&
                  {push_data.b2, push_data.b3} == ts_r[31:16] + 16'h0001);
    endproperty
    a_roll_entry: assert property (p_roll_entry)
        else $error("rollover entry missing");

    property p_reset_clears;
        @(posedge ref_clk) mod_rst_r |=> (out_r == '0 && buf_empty && wd_en_r && loss_r);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset state wrong");

    property p_commit_all;
        @(posedge ref_clk) disable iff (mod_rst_r)
        (wr_commit && !comm_to) |=> (field_out == $past(shadow_r));
    endproperty
    a_commit_all: assert property (p_commit_all)
        else $error("outputs not updated together");

    property p_comm_loss;
        @(posedge ref_clk) disable iff (mod_rst_r)
        comm_to |=> (field_out == '0 && loss_r) ##1 loss_r;
    endproperty
    a_comm_loss: assert property (p_comm_loss)
        else $error("communication loss not handled");

    property p_wd_sticky;
        @(posedge ref_clk) disable iff (mod_rst_r)
        wd_en_r |=> (wd_en_r || mod_rst_r);
    endproperty
    a_wd_sticky: assert property (p_wd_sticky)
        else $error("watchdog disabled without reset");

    property p_bite_resets;
        @(posedge ref_clk) disable iff (!reset_n)
        wd_bite_r |=> (mod_rst_r && !module_reset_n);
    endproperty
    a_bite_resets: assert property (p_bite_resets)
        else $error("watchdog bite did not reset");

endmodule

//--- src/field_io_map.svh
`ifndef FIELD_IO_MAP_SVH
`define FIELD_IO_MAP_SVH

// Time base
`define CLK_PERIOD_NS   10
`define MS_PERIOD_NS    1000000
`define MS_CYCLES       (`MS_PERIOD_NS / `CLK_PERIOD_NS)

// Field widths
`define NUM_IO          64
`define IDX_W           6
`define MON_BIT         39

// Millisecond-tick counts
`define WD_TIMEOUT_MS   7'h64
`define MON_PERIOD_MS   7'h64
`define MON_SPAN_MS     12'hdac
`define COMM_LOSS_MS    11'h7d0

// Filter and entry constants
`define FILT_DEFAULT    8'h05
`define ROLL_ID         8'hff
`define BUF_AW          10

// Register offsets
`define A_CTRL          8'h00
`define A_STATUS        8'h04
`define A_OUT_LO        8'h08
`define A_OUT_HI        8'h0c
`define A_OUT_COMMIT    8'h10
`define A_IN_LO         8'h14
`define A_IN_HI         8'h18
`define A_TSTAMP        8'h1c
`define A_CFG_SEL       8'h20
`define A_CFG_DATA      8'h24
`define A_BUF_DATA      8'h28
`define A_BUF_COUNT     8'h2c
`define A_BUF_CONFIRM   8'h30
`define A_BUF_REWIND    8'h34

// Control bits
`define CTRL_WD_EN      0
`define CTRL_WD_KICK    1
`define CTRL_MON_TOG    2
`define CTRL_STAT_REQ   3
`define CTRL_SYNC_EXT   4
`define CTRL_RESYNC     5

`endif

//--- src/field_io_pkg.sv
package field_io_pkg;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // One buffered entry, byte 1 first
    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } entry_t;

    // Per-input filter configuration
    typedef struct packed {
        logic       report;
        logic       ignore;
        logic [7:0] off_cnt;
        logic [7:0] on_cnt;
    } in_cfg_t;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN  = 2'b10
    } scan_state_t;

endpackage

//--- src/entry_buffer.sv
`timescale 1ns/1ps
`include "field_io_map.svh"

module entry_buffer (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Producer
    input  wire logic                 push,
    input  field_io_pkg::entry_t      push_data,
    // Consumer
    input  wire logic                 pull,
    input  wire logic                 confirm,
    input  wire logic                 rewind,
    output field_io_pkg::entry_t      peek_data,
    output logic [`BUF_AW:0]          count,
    output logic                      full,
    output logic                      empty
);
    import field_io_pkg::*;

    entry_t           mem [0:(1 << `BUF_AW) - 1];
    logic [`BUF_AW:0] wr_ptr_r;
    logic [`BUF_AW:0] rd_ptr_r;
    logic [`BUF_AW:0] pk_ptr_r;

    // Occupancy counts sent-but-unconfirmed entries too
    assign count     = wr_ptr_r - rd_ptr_r;
    assign full      = (count[`BUF_AW] == 1'b1);
    assign empty     = (count == '0);
    assign peek_data = (pk_ptr_r == wr_ptr_r) ? entry_t'(24'h000000)
                                              : mem[pk_ptr_r[`BUF_AW-1:0]];

    // Storage; a full buffer drops new entries
    always_ff @(posedge ref_clk) begin
        if (push && !full) begin
            mem[wr_ptr_r[`BUF_AW-1:0]] <= push_data;
        end
    end

    // Write pointer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
        end else if (push && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // Entries leave only on confirmation, so a lost block can be resent
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_ptr_r <= '0;
            pk_ptr_r <= '0;
        end else if (confirm) begin
            rd_ptr_r <= pk_ptr_r;
        end else if (rewind) begin
            pk_ptr_r <= rd_ptr_r;
        end else if (pull && (pk_ptr_r != wr_ptr_r)) begin
            pk_ptr_r <= pk_ptr_r + 1'b1;
        end
    end

endmodule

//--- verif/cpu_link_model.sv
`timescale 1ns/1ps
module cpu_link_model (
    // Clock and read data
    input  wire logic               ref_clk,
    input  wire logic [31:0]        rdata,
    // Register port master
    output field_io_pkg::bus_req_t  bus_req
);
    import field_io_pkg::*;
    initial bus_req = '0;
    // One-cycle write, idle cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask
    // Data taken once the answering edge has landed
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 v = rdata;
    endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "field_io_map.svh"
module tb_top;
    import field_io_pkg::*;
    localparam int unsigned MS = 80;
    logic        ref_clk;
    logic        reset_n;
    logic        cpu_reset_n;
    logic        module_reset_n;
    logic        ph;
    logic        jmp;
    logic [63:0] field_in_n;
    logic [63:0] field_out;
    logic [63:0] o;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [31:0] e1;
    logic [31:0] e2;
    logic [31:0] r;
    bus_req_t    bus_req;
    int          failures;
    int          n_compared;
    int          cyc;
    int          n;
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Short millisecond, yet longer than one 64-cycle scan
    field_io_scan_timestamp #(.MS_CYCLES(MS)) u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .cpu_reset_n(cpu_reset_n),
        .module_reset_n(module_reset_n), .field_in_n(field_in_n),
        .field_out(field_out), .mains_phase_ref(ph), .monitor_jumper(jmp),
        .bus_req(bus_req), .rdata(rdata));
    cpu_link_model u_cpu (.ref_clk(ref_clk), .rdata(rdata), .bus_req(bus_req));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Expected rising transition entry
    function automatic logic [31:0] ent(input logic [5:0] i, input logic [15:0] ts);
        return {8'h0, 2'b10, i, ts};
    endfunction
    // Phase pin square wave, 32 cycles, well under a millisecond
    always @(posedge ref_clk) ph <= cyc[4];
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        reset_n = 1'b0;
        cpu_reset_n = 1'b1;
        jmp = 1'b0;
        field_in_n = '1;
        void'($urandom(32'he35bace2));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(field_out, 64'h0);
        u_cpu.rd(`A_STATUS, d);
        chk(d[2:0], 3'b111);
        u_cpu.rd(8'hfc, d);
        chk(d, 32'h0);
        u_cpu.wr(`A_CFG_SEL, 32'h3);
        u_cpu.wr(`A_CFG_DATA, 32'h20000);
        u_cpu.wr(`A_CFG_SEL, 32'h7);
        u_cpu.wr(`A_CFG_DATA, 32'h20000);
        r = $urandom();
        field_in_n[63:32] <= r;
        repeat (8 * MS) @(posedge ref_clk);
        // Two reported inputs change in one scan
        field_in_n[3] <= 1'b0;
        field_in_n[7] <= 1'b0;
        repeat (3 * MS) @(posedge ref_clk);
        u_cpu.rd(`A_BUF_COUNT, d);
        chk(d, 32'h2);
        u_cpu.rd(`A_BUF_DATA, e1);
        u_cpu.rd(`A_BUF_DATA, e2);
        chk(e1, ent(6'h3, e2[15:0]));
        chk(e2, ent(6'h7, e1[15:0]));
        u_cpu.wr(`A_BUF_REWIND, 32'h0);
        u_cpu.rd(`A_BUF_DATA, d);
        chk(d, e1);
        u_cpu.rd(`A_BUF_DATA, d);
        u_cpu.wr(`A_BUF_CONFIRM, 32'h0);
        u_cpu.rd(`A_BUF_COUNT, d);
        chk(d, 32'h0);
        u_cpu.rd(`A_BUF_DATA, d);
        chk(d, 32'h0);
        u_cpu.rd(`A_IN_HI, d);
        chk(d, 32'(~r));
        // Short pulse on a default-filtered input is dropped
        field_in_n[10] <= 1'b0;
        repeat (2 * MS) @(posedge ref_clk);
        field_in_n[10] <= 1'b1;
        repeat (8 * MS) @(posedge ref_clk);
        u_cpu.rd(`A_IN_LO, d);
        chk(d, 32'h88);
        field_in_n[10] <= 1'b0;
        repeat (10 * MS) @(posedge ref_clk);
        u_cpu.rd(`A_IN_LO, d);
        chk(d, 32'h488);
        u_cpu.rd(`A_TSTAMP, e1);
        repeat (10 * MS - 2) @(posedge ref_clk);
        u_cpu.rd(`A_TSTAMP, e2);
        chk(e2 - e1, 32'd10);
        // Phase pin edges keep restarting the divider, so no tick comes
        u_cpu.wr(`A_CTRL, 32'h10);
        repeat (40) @(posedge ref_clk);
        u_cpu.rd(`A_TSTAMP, e1);
        repeat (4 * MS) @(posedge ref_clk);
        u_cpu.rd(`A_TSTAMP, e2);
        chk(e2, e1);
        u_cpu.wr(`A_CTRL, 32'h0);
        u_cpu.wr(`A_CTRL, 32'h8);
        u_cpu.rd(`A_STATUS, d);
        chk(d[1], 1'b1);
        for (int i = 0; i < 3; i++) begin
            o[31:0] = $urandom();
            if (i == 0) o[63:32] = $urandom();
            u_cpu.wr(`A_OUT_LO, o[31:0]);
            u_cpu.wr(`A_OUT_HI, o[63:32]);
            u_cpu.wr(`A_OUT_COMMIT, 32'h0);
            #1 chk(field_out, o);
        end
        // Monitor bit follows a command only with the jumper fitted
        u_cpu.wr(`A_CTRL, 32'h4);
        jmp <= 1'b1;
        #1 chk(field_out, o);
        repeat (3) @(posedge ref_clk);
        u_cpu.wr(`A_CTRL, 32'h4);
        #1 chk(field_out, o ^ (64'h1 << `MON_BIT));
        u_cpu.rd(`A_STATUS, d);
        chk(d[1], 1'b0);
        chk(d[4], 1'b1);
        // Kick and restart the divider, then starve the watchdog
        u_cpu.wr(`A_CTRL, 32'h22);
        n = 0;
        while (module_reset_n === 1'b1 && n < 100 * MS + 50) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n, 100 * MS + 2);
        #1 chk(field_out, 64'h0);
        u_cpu.rd(`A_STATUS, d);
        chk(d[1:0], 2'b11);
        repeat (20) @(posedge ref_clk);
        cpu_reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk(module_reset_n, 1'b0);
        give_verdict();
    end
endmodule
